// [core/pwr_wake_regs.svh]
// constants for the power-down, wake and start-mode block
// assumes a 100 MHz sys_clk; included by bare name
`ifndef PWR_WAKE_REGS_SVH
`define PWR_WAKE_REGS_SVH
`define CLK_PERIOD_NS 10
`define WAKE_SETTLE_NS 100
`define WAKE_SETTLE_CYC ((`WAKE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PCTL_IDLE_BIT 0
`define PCTL_PD_BIT 1
`define PCTL_RESET_VAL 8'h00
`define WAKE_SRC_W 3
`define WAKE_SRC_TIC 0
`define WAKE_SRC_SER 1
`define WAKE_SRC_EXT0 2
`endif

// [core/pwr_wake_pkg.sv]
// types for the power-down, wake and start-mode block
// assumes nothing beyond the shared constants header
package pwr_wake_pkg;
    // start mode chosen by the strap at reset release
    typedef enum logic [1:0] {MODE_NORMAL, MODE_DOWNLOAD_DEBUG} start_mode_e;
    // power-control fields that the core writes
    typedef struct packed {
        logic pd_req;
        logic serial_wake_enable;
        logic ext0_wake_enable;
        logic oscillator_powerdown_bit;
    } power_ctl_s;
    // pending interrupt sources seen by the block
    typedef struct packed {
        logic ext0;
        logic serial;
        logic interval_counter;
    } wake_src_s;
    // what the block tells the core
    typedef struct packed {
        logic core_clk_en;
        logic pll_en;
        logic osc_en;
        logic tic_clk_en;
        logic wake_irq;
        logic resume;
    } power_out_s;
endpackage

// [core/strap_sync.sv]
// two-flop synchroniser for the boot-select strap pin
// assumes the pin is asynchronous to sys_clk and stable around reset release
`timescale 1ns/100ps
module strap_sync
(
    input wire logic sys_clk,
    input wire logic pin_in,
    output logic pin_sync
);
    logic meta_r; // first stage, read only by second stage
    // no reset on purpose: the stages keep tracking the pin while reset is
    // held, so the level is already settled when the start mode is captured
    always_ff @(posedge sys_clk)
    begin
        meta_r <= pin_in;
        pin_sync <= meta_r;
    end
endmodule

// [core/powerdown_wake_boot_select.sv]
// power-down control, wake arbitration and strap-selected start mode
// assumes the core drops pd_req before its return from the wake routine,
// and runs its own service routine and return when wake_irq rises
`include "pwr_wake_regs.svh"
`timescale 1ns/100ps
module powerdown_wake_boot_select
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic boot_select_pin,
    input pwr_wake_pkg::power_ctl_s power_control_reg,
    input pwr_wake_pkg::wake_src_s wake_src,
    input wire logic irq_taken,
    input wire logic reti_done,
    input wire logic emu_rx,
    output pwr_wake_pkg::power_out_s pwr_out,
    output pwr_wake_pkg::start_mode_e start_mode,
    output logic reset_vector_start,
    output logic emu_active,
    output logic emu_tx,
    output logic emu_tx_oe_n,
    output logic [`WAKE_SRC_W-1:0] wake_cause
);
    // RUN: core running; DOWN: pll and core clock stopped;
    // SETTLE: pll relocking after a wake, core still held;
    // SERVICE: core runs the wake routine until its return
    typedef enum logic [1:0] {ST_RUN, ST_DOWN, ST_SETTLE, ST_SERVICE} pwr_state_e;

    pwr_state_e state_r; // power state
    logic strap_s; // synchronised strap level
    logic sampled_r; // strap has been captured since reset
    logic [7:0] settle_r; // clock settle countdown
    logic [`WAKE_SRC_W-1:0] wake_hit; // qualified wake sources
    logic emu_rx_meta_r; // emulation line, first sync stage
    logic emu_rx_s; // emulation line, synchronised
    logic resume_r; // one-cycle return pulse
    logic irq_r; // wake interrupt request level

    // the strap is asynchronous to sys_clk, so it is synchronised before the
    // capture below reads it; the synchroniser runs through reset
    strap_sync u_strap
    (
        .sys_clk(sys_clk),
        .pin_in(boot_select_pin),
        .pin_sync(strap_s)
    );

    // qualify sources: the serial and ext0 paths are gated by their
    // enables, the interval counter always wakes
    // a refused source is only masked here; it stays pending for the core
    function automatic logic [`WAKE_SRC_W-1:0] qualify(input pwr_wake_pkg::wake_src_s s,
                                                        input pwr_wake_pkg::power_ctl_s c);
        logic [`WAKE_SRC_W-1:0] q;
        q = '0;
        q[`WAKE_SRC_TIC] = s.interval_counter;
        q[`WAKE_SRC_SER] = s.serial & c.serial_wake_enable;
        q[`WAKE_SRC_EXT0] = s.ext0 & c.ext0_wake_enable;
        return q;
    endfunction

    // shared by the entry refusal and the wake detection
    assign wake_hit = qualify(wake_src, power_control_reg);

    // strap capture: one sample after release, then frozen until reset
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sampled_r <= 1'b0;
            start_mode <= pwr_wake_pkg::MODE_NORMAL;
        end
        else if (!sampled_r)
        begin
            // the synchroniser has tracked the pin through reset, so strap_s
            // already holds the settled level here; later strap changes are
            // ignored until the next reset
            sampled_r <= 1'b1;
            // download and debug are one mode
            start_mode <= strap_s ? pwr_wake_pkg::MODE_DOWNLOAD_DEBUG
                                  : pwr_wake_pkg::MODE_NORMAL;
        end
    end

    // one-cycle start pulse: everything cleared, run from the vector
    // it rises on the same edge as the strap capture, so the core never starts in a stale mode
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            reset_vector_start <= 1'b0;
        else
            reset_vector_start <= !sampled_r;
    end

    // emulation line sync; the controller is active only in strap-high mode
    // synchronised because the emulator drives the pin from its own clock
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            emu_rx_meta_r <= 1'b0;
            emu_rx_s <= 1'b0;
        end
        else
        begin
            emu_rx_meta_r <= emu_rx;
            emu_rx_s <= emu_rx_meta_r;
        end
    end

    // single-pin emulation echo: drives low-active enable only when the
    // emulator pulls the line low; limitation, no protocol is decoded here
    // the echo is registered so the pin never glitches on a sync edge
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            emu_active <= 1'b0;
            emu_tx <= 1'b0;
            emu_tx_oe_n <= 1'b1;
        end
        else
        begin
            emu_active <= sampled_r && (start_mode == pwr_wake_pkg::MODE_DOWNLOAD_DEBUG);
            emu_tx <= emu_rx_s;
            emu_tx_oe_n <= !(emu_active && !emu_rx_s);
        end
    end

    // power state machine
    // the settle count is loaded on every wake, so each wake sees the full
    // relock time; pd_req must drop before the return or the part goes down again
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_r <= ST_RUN;
            settle_r <= 8'h00;
            wake_cause <= '0;
        end
        else
        begin
            unique case (state_r)
                ST_RUN:
                begin
                    // a pending enabled wake source aborts entry, so no event is lost
                    if (power_control_reg.pd_req && (wake_hit == '0))
                        state_r <= ST_DOWN;
                end
                ST_DOWN:
                begin
                    if (wake_hit != '0)
                    begin
                        wake_cause <= wake_hit;
                        settle_r <= 8'(`WAKE_SETTLE_CYC);
                        state_r <= ST_SETTLE;
                    end
                end
                ST_SETTLE:
                begin
                    // pll needs time to relock before the core clock returns
                    if (settle_r <= 8'h01)
                        state_r <= ST_SERVICE;
                    else
                        settle_r <= settle_r - 8'h01;
                end
                ST_SERVICE:
                begin
                    if (reti_done)
                    begin
                        state_r <= ST_RUN;
                        wake_cause <= '0;
                    end
                end
            endcase
        end
    end

    // wake interrupt request held until the core takes it
    // the set branch wins over the take, so a new wake is never dropped
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            irq_r <= 1'b0;
        else if (state_r == ST_SETTLE && settle_r <= 8'h01)
            irq_r <= 1'b1;
        else if (irq_taken)
            irq_r <= 1'b0;
    end

    // resume pulse: return lands after the power-down instruction
    // limitation: the resume address itself is kept by the core, not here
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            resume_r <= 1'b0;
        else
            resume_r <= (state_r == ST_SERVICE) && reti_done;
    end

    // clock gating: pll stops while down, core clock while down or settling
    // the oscillator keeps running in power-down unless its power-down bit is
    // set; the interval counter runs from it, so it can still wake the part
    always_comb
    begin
        pwr_out.core_clk_en = (state_r == ST_RUN) || (state_r == ST_SERVICE);
        pwr_out.pll_en = (state_r != ST_DOWN);
        pwr_out.osc_en = (state_r != ST_DOWN) || !power_control_reg.oscillator_powerdown_bit;
        pwr_out.tic_clk_en = pwr_out.osc_en;
        pwr_out.wake_irq = irq_r;
        pwr_out.resume = resume_r;
    end
endmodule

// [verif/pwr_wake_props.sv]
// checker: power-down, wake and start-mode assertions
// bound onto the top module, sees its ports only
`timescale 1ns/100ps
`include "pwr_wake_regs.svh"
module pwr_wake_props
(
    input wire logic sys_clk,
    input wire logic reset,
    input pwr_wake_pkg::power_ctl_s power_control_reg,
    input pwr_wake_pkg::wake_src_s wake_src,
    input wire logic reti_done,
    input pwr_wake_pkg::power_out_s pwr_out,
    input pwr_wake_pkg::start_mode_e start_mode,
    input wire logic reset_vector_start,
    input wire logic [2:0] wake_cause
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    wire cor = pwr_out.core_clk_en; // core clock running
    wire pll = pwr_out.pll_en; // low only while powered down
    wire irq = pwr_out.wake_irq; // wake interrupt to the core
    logic [7:0] dark_cnt; // cycles in a row with pll up and core clock stopped
    // counting the relock gap keeps the settle check free of a long repetition
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            dark_cnt <= 8'h00;
        else if (pll && !cor)
            dark_cnt <= dark_cnt + 8'h01;
        else
            dark_cnt <= 8'h00;
    end
    // a pending wake or service keeps power-down refused, hence the long guard
    a_pd_stop: assert property (power_control_reg.pd_req && cor && !irq && !wake_cause && !wake_src
        |=> !cor && !pll) else $error("clocks not stopped");
    a_osc_bit: assert property (!cor && !pll |->
        pwr_out.osc_en == !power_control_reg.oscillator_powerdown_bit) else $error("osc enable wrong");
    a_tic_wake: assert property (!pll && wake_src.interval_counter |=> pll && wake_cause[0]) else $error("no tic wake");
    a_settle_len: assert property ($rose(pll) && !cor |->
        ##10 cor && irq && dark_cnt == 8'(`WAKE_SETTLE_CYC)) else $error("settle length wrong");
    a_ser_gate: assert property (!pll && wake_src == 3'h2 |=> pll == $past(power_control_reg.serial_wake_enable))
        else $error("serial gate wrong");
    a_ext_gate: assert property (!pll && wake_src == 3'h4 |=> pll == $past(power_control_reg.ext0_wake_enable))
        else $error("ext0 gate wrong");
    a_resume_pulse: assert property (reti_done && cor && wake_cause |=> pwr_out.resume)
        else $error("no resume");
    a_mode_held: assert property (!$past(reset) && !$past(reset, 2) |-> $stable(start_mode))
        else $error("mode changed");
    a_vector_start: assert property ($fell(reset) |-> cor && pll ##[1:2] reset_vector_start)
        else $error("no vector start");
    c_tic: cover property (irq && wake_cause == 3'h1);
    c_ser: cover property (irq && wake_cause == 3'h2);
    c_ext: cover property (irq && wake_cause == 3'h4);
endmodule
bind powerdown_wake_boot_select pwr_wake_props chk (.sys_clk, .reset, .power_control_reg, .wake_src,
    .reti_done, .pwr_out, .start_mode, .reset_vector_start, .wake_cause);

// [verif/core_partner.sv]
// core-side model: takes the wake interrupt, runs a routine, returns
// assumes the same sys_clk as the block
`timescale 1ns/100ps
module core_partner
(
    input wire logic sys_clk,
    input wire logic wake_irq,
    input wire logic [3:0] isr_len,
    output logic irq_taken,
    output logic reti_done
);
    int cnt = 0; // cycles left in the routine
    initial {irq_taken, reti_done} = 2'h0;
    // acknowledge at once; isr_len varies so slow returns are covered
    always @(posedge sys_clk)
    begin
        irq_taken <= wake_irq && !irq_taken;
        reti_done <= cnt == 1;
        if (wake_irq && !irq_taken)
            cnt <= isr_len + 1;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule

// [verif/powerdown_wake_boot_select_tb.sv]
// bench for power-down, wake and start mode
// assumes core_partner stands in for the core
`timescale 1ns/100ps
module powerdown_wake_boot_select_tb;
    logic sys_clk = 0, reset = 1, strap = 0, emu_rx = 0, irq_taken, reti_done, vec, emu_act, emu_tx, emu_oe_n;
    pwr_wake_pkg::power_ctl_s ctl = '0; // power control levels
    pwr_wake_pkg::wake_src_s src = '0; // interrupt sources
    pwr_wake_pkg::power_out_s po;
    pwr_wake_pkg::start_mode_e mode;
    logic [2:0] cause, exp;
    logic [3:0] len = 4'h1; // routine length in the core model
    int mismatches = 0, tests_run = 0, cyc = 0, i, n;
    // rows: source, serial enable, ext0 enable, osc off, cause (0 = refused)
    logic [8:0] rows [5] = '{9'h041, 9'h0AA, 9'h090, 9'h11C, 9'h120};
    powerdown_wake_boot_select dut (.sys_clk, .reset, .boot_select_pin(strap), .power_control_reg(ctl),
        .wake_src(src), .irq_taken, .reti_done, .emu_rx, .pwr_out(po), .start_mode(mode),
        .reset_vector_start(vec), .emu_active(emu_act), .emu_tx, .emu_tx_oe_n(emu_oe_n), .wake_cause(cause));
    core_partner cp (.sys_clk, .wake_irq(po.wake_irq), .isr_len(len), .irq_taken, .reti_done);
    initial forever #5 sys_clk = ~sys_clk;
    task automatic chk(logic [3:0] seen, logic [3:0] want);
        tests_run++;
        if (seen !== want)
            $display("Error at %0t: saw %h want %h", $time, seen, want);
        mismatches += seen !== want;
    endtask
    task step(int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // strap settles well before release, as the synchroniser needs
    task rst(logic s);
        reset = 1;
        strap = s;
        step(6);
        reset = 0;
    endtask
    task await(logic res);
        n = 0;
        while (!(res ? po.resume : po.wake_irq) && n < 40)
        begin
            step(1);
            n++;
        end
    endtask
    task close_out;
        $display("tests_run %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard, far above the roughly 130 cycles needed
    always @(posedge sys_clk)
        if (++cyc == 3000)
        begin
            mismatches++;
            close_out;
        end
    initial
    begin
        rst(0);
        step(1);
        chk(vec, 1);
        step(1);
        chk(vec, 0);
        chk(mode, pwr_wake_pkg::MODE_NORMAL);
        chk(emu_oe_n, 1);
        $display("reset test done");
        for (i = 0; i < 5; i++)
        begin
            {ctl.serial_wake_enable, ctl.ext0_wake_enable, ctl.oscillator_powerdown_bit} = rows[i][5:3];
            len = 4'(i + 1);
            ctl.pd_req = 1;
            step(1);
            ctl.pd_req = 0;
            step(1);
            chk({po.core_clk_en, po.pll_en, po.osc_en, po.tic_clk_en}, {2'h0, !rows[i][3], !rows[i][3]});
            src = rows[i][8:6];
            step(3);
            exp = rows[i][2:0] ? rows[i][2:0] : 3'h1;
            // a refused source must leave the part asleep; wake it by the interval counter
            if (!rows[i][2:0])
            begin
                chk(po.pll_en, 0);
                src = 3'h1;
            end
            await(0);
            src = '0;
            chk({po.wake_irq, cause}, {1'b1, exp});
            await(1);
            chk({po.resume, po.core_clk_en}, 2'h3);
            $display("row %0d done", i);
        end
        // power-down asked while a wake is pending is refused
        src = 3'h1;
        ctl.pd_req = 1;
        step(2);
        chk(po.core_clk_en, 1);
        $display("refusal test done");
        src = '0;
        step(1);
        // reset in mid power-down restores the clocks
        rst(1);
        ctl.pd_req = 0;
        step(3);
        chk({po.core_clk_en, po.pll_en}, 2'h3);
        chk(mode, pwr_wake_pkg::MODE_DOWNLOAD_DEBUG);
        strap = 0;
        step(5);
        chk(mode, pwr_wake_pkg::MODE_DOWNLOAD_DEBUG);
        chk(emu_act, 1);
        chk({emu_tx, emu_oe_n}, 2'h0);
        emu_rx = 1;
        step(4);
        chk({emu_tx, emu_oe_n}, 2'h3);
        $display("strap tests done");
        close_out;
    end
endmodule
